// ### hdl/fsw_status_guard.sv
// status word, write latch, busy and write-protect gating of a serial flash
`timescale 1ns/100ps
`include "fsw_consts.svh"
module fsw_status_guard
    import fsw_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // serial link pins
    input wire logic sclk_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic write_guard_n_i,
    output logic so_o,
    output logic so_oe_n_o,
    // status and array side
    output logic [15:0] status_o,
    output logic array_go_o,
    output fsw_op_t array_op_o,
    output logic [23:0] array_addr_o,
    output logic refused_o
);
    localparam int BUSY_MAX = 200;

    // pin synchronisers
    logic sclk_q1, sclk_q2, sclk_q3;
    logic cs_q1, cs_q2, cs_q3;
    logic si_q1, si_q2;
    logic wp_q1, wp_q2;

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            {sclk_q1, sclk_q2, sclk_q3} <= 3'h0;
            {cs_q1, cs_q2, cs_q3} <= 3'h7;
            {si_q1, si_q2} <= 2'h0;
            {wp_q1, wp_q2} <= 2'h3;
        end
        else
        begin
            {sclk_q1, sclk_q2, sclk_q3} <= {sclk_i, sclk_q1, sclk_q2};
            {cs_q1, cs_q2, cs_q3} <= {cs_n_i, cs_q1, cs_q2};
            {si_q1, si_q2} <= {si_i, si_q1};
            {wp_q1, wp_q2} <= {write_guard_n_i, wp_q1};
        end
    end

    logic sclk_rise, sclk_fall, frame, frame_end;
    assign sclk_rise = sclk_q2 & ~sclk_q3;
    assign sclk_fall = ~sclk_q2 & sclk_q3;
    assign frame = ~cs_q2;
    assign frame_end = cs_q2 & ~cs_q3;

    // control state
    fsw_state_t state, next_state;
    logic [15:0] sr, next_sr;
    logic [7:0] busy_cnt, next_busy_cnt;
    logic [2:0] bit_idx, next_bit_idx;
    logic [2:0] byte_cnt, next_byte_cnt;
    logic [7:0] shift, next_shift;
    logic [7:0] cmd, next_cmd;
    logic [23:0] addr, next_addr;
    logic [7:0] wr_b1, next_wr_b1;
    logic [7:0] wr_b2, next_wr_b2;
    logic reset_arm, next_reset_arm;
    logic next_so, next_so_oe_n, next_go, next_refused;
    fsw_op_t next_op;
    logic [23:0] next_array_addr;

    // region of the captured command
    logic [23:0] span, first_addr, last_addr;
    logic region_hit, lock_ok, chip_ok;
    always_comb
    begin
        case (cmd)
            `FSW_CMD_PAGE_WRITE: span = `FSW_SPAN_PAGE;
            `FSW_CMD_SECT_CLEAR: span = `FSW_SPAN_SECT;
            `FSW_CMD_BLK32_CLEAR: span = `FSW_SPAN_BLK32;
            `FSW_CMD_BLK64_CLEAR: span = `FSW_SPAN_BLK64;
            default: span = `FSW_SPAN_PAGE;
        endcase
    end
    assign first_addr = addr & ~span;
    assign last_addr = first_addr | span;

    fsw_guard_decode u_decode (
        .guard_bits_i(sr[`FSW_BIT_GUARD_HI:`FSW_BIT_GUARD_LO]),
        .complement_i(sr[`FSW_BIT_CMP]),
        .first_addr_i(first_addr),
        .last_addr_i(last_addr),
        .hit_o(region_hit)
    ); // decoded inside

    // status lock modes; the pin matters only in mode 01
    always_comb
    begin
        case ({sr[`FSW_BIT_LOCK_HI], sr[`FSW_BIT_LOCK_LO]})
            2'b00: lock_ok = 1'b1;
            2'b01: lock_ok = wp_q2;
            2'b10: lock_ok = 1'b0;
            default: lock_ok = 1'b0;
        endcase
    end

    // chip erase allowed only for all-clear or all-set low guard bits
    assign chip_ok = ((sr[4:2] == 3'h0) && !sr[`FSW_BIT_CMP])
        || ((sr[4:2] == 3'h7) && sr[`FSW_BIT_CMP]);

    // next-state logic: serial capture, readout, execution, busy timer
    always_comb
    begin
        next_state = state;
        next_sr = sr;
        next_busy_cnt = busy_cnt;
        next_bit_idx = bit_idx;
        next_byte_cnt = byte_cnt;
        next_shift = shift;
        next_cmd = cmd;
        next_addr = addr;
        next_wr_b1 = wr_b1;
        next_wr_b2 = wr_b2;
        next_reset_arm = reset_arm;
        next_so = so_o;
        next_so_oe_n = so_oe_n_o;
        next_go = 1'b0;
        next_refused = 1'b0;
        next_op = array_op_o;
        next_array_addr = array_addr_o;
        // bits in on rising link clock, msb first
        if (frame && sclk_rise)
        begin
            next_shift = {shift[6:0], si_q2};
            next_bit_idx = bit_idx + 3'h1;
            if (bit_idx == 3'h7)
            begin
                if (byte_cnt != 3'h7)
                    next_byte_cnt = byte_cnt + 3'h1;
                case (byte_cnt)
                    3'h0: next_cmd = {shift[6:0], si_q2};
                    3'h1:
                    begin
                        next_addr[23:16] = {shift[6:0], si_q2};
                        next_wr_b1 = {shift[6:0], si_q2};
                    end
                    3'h2:
                    begin
                        next_addr[15:8] = {shift[6:0], si_q2};
                        next_wr_b2 = {shift[6:0], si_q2};
                    end
                    3'h3: next_addr[7:0] = {shift[6:0], si_q2};
                    default: next_shift = {shift[6:0], si_q2};
                endcase
            end
        end
        // status byte out on falling link clock
        if (frame && sclk_fall && byte_cnt != 3'h0
            && (cmd == `FSW_CMD_READ_SR1 || cmd == `FSW_CMD_READ_SR2))
        begin
            next_so_oe_n = 1'b0;
            if (cmd == `FSW_CMD_READ_SR1)
                next_so = sr[~bit_idx];
            else
                next_so = sr[{1'b1, ~bit_idx}];
        end
        if (!frame)
        begin
            next_bit_idx = 3'h0;
            next_byte_cnt = 3'h0;
            next_so_oe_n = 1'b1;
            next_so = 1'b0;
        end
        case (state)
            FSW_BUSY:
            begin
                next_busy_cnt = busy_cnt - 8'h01;
                if (busy_cnt == 8'h01)
                begin
                    next_state = FSW_IDLE;
                    next_sr[`FSW_BIT_BUSY] = 1'b0;
                    next_sr[`FSW_BIT_LATCH] = 1'b0;
                    next_op = FSW_OP_NONE;
                end
            end
            FSW_IDLE:
            begin
                // only whole-byte frames execute
                if (frame_end && bit_idx == 3'h0 && byte_cnt != 3'h0)
                begin
                    next_reset_arm = (cmd == `FSW_CMD_RESET_ARM);
                    case (cmd)
                        `FSW_CMD_WRITE_ALLOW: next_sr[`FSW_BIT_LATCH] = 1'b1;
                        `FSW_CMD_WRITE_FORBID: next_sr[`FSW_BIT_LATCH] = 1'b0;
                        `FSW_CMD_RESET_GO:
                        begin
                            if (reset_arm)
                            begin
                                next_sr[`FSW_BIT_LATCH] = 1'b0;
                                next_sr[`FSW_BIT_PROG_PAUSE] = 1'b0;
                                next_sr[`FSW_BIT_ERASE_PAUSE] = 1'b0;
                            end
                        end
                        `FSW_CMD_STATUS_WRITE:
                        begin
                            if (byte_cnt >= 3'h2 && sr[`FSW_BIT_LATCH] && lock_ok)
                            begin
                                // writable fields only; latch, busy and pauses kept
                                next_sr[7:0] = (wr_b1 & `FSW_SR1_WR_MASK)
                                    | (sr[7:0] & ~`FSW_SR1_WR_MASK);
                                if (byte_cnt >= 3'h3)
                                begin
                                    next_sr[`FSW_BIT_CMP] = wr_b2[6];
                                    next_sr[`FSW_BIT_OTP_HI:`FSW_BIT_OTP_LO] =
                                        sr[`FSW_BIT_OTP_HI:`FSW_BIT_OTP_LO] | wr_b2[5:3];
                                    next_sr[`FSW_BIT_QUAD] = wr_b2[1];
                                    next_sr[`FSW_BIT_LOCK_HI] = wr_b2[0];
                                end
                                next_sr[`FSW_BIT_BUSY] = 1'b1;
                                next_state = FSW_BUSY;
                                next_busy_cnt = 8'(`FSW_BUSY_CYC);
                                next_op = FSW_OP_STATUS;
                            end
                            else if (byte_cnt >= 3'h2)
                                next_refused = 1'b1;
                        end
                        `FSW_CMD_PAGE_WRITE, `FSW_CMD_SECT_CLEAR,
                        `FSW_CMD_BLK32_CLEAR, `FSW_CMD_BLK64_CLEAR:
                        begin
                            if (byte_cnt >= ((cmd == `FSW_CMD_PAGE_WRITE) ? 3'h5 : 3'h4))
                            begin
                                if (sr[`FSW_BIT_LATCH] && !region_hit)
                                begin
                                    next_sr[`FSW_BIT_BUSY] = 1'b1;
                                    next_state = FSW_BUSY;
                                    next_busy_cnt = 8'(`FSW_BUSY_CYC);
                                    next_go = 1'b1;
                                    next_array_addr = first_addr;
                                    case (cmd)
                                        `FSW_CMD_PAGE_WRITE: next_op = FSW_OP_PROG;
                                        `FSW_CMD_SECT_CLEAR: next_op = FSW_OP_SECT;
                                        `FSW_CMD_BLK32_CLEAR: next_op = FSW_OP_BLK32;
                                        default: next_op = FSW_OP_BLK64;
                                    endcase
                                end
                                else
                                    next_refused = 1'b1;
                            end
                        end
                        `FSW_CMD_CHIP_CLEAR_A, `FSW_CMD_CHIP_CLEAR_B:
                        begin
                            if (sr[`FSW_BIT_LATCH] && chip_ok)
                            begin
                                next_sr[`FSW_BIT_BUSY] = 1'b1;
                                next_state = FSW_BUSY;
                                next_busy_cnt = 8'(`FSW_BUSY_CYC);
                                next_go = 1'b1;
                                next_op = FSW_OP_CHIP;
                                next_array_addr = 24'h000000;
                            end
                            else
                                next_refused = 1'b1;
                        end
                        default: next_reset_arm = (cmd == `FSW_CMD_RESET_ARM);
                    endcase
                end
            end
            default: next_state = FSW_IDLE;
        endcase
    end

    // register stage; reset stands for power-up, clearing the lock-down bits
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state <= FSW_IDLE;
            sr <= `FSW_SR_RESET;
            busy_cnt <= 8'h00;
            bit_idx <= 3'h0;
            byte_cnt <= 3'h0;
            shift <= 8'h00;
            cmd <= 8'h00;
            addr <= 24'h000000;
            wr_b1 <= 8'h00;
            wr_b2 <= 8'h00;
            reset_arm <= 1'b0;
            so_o <= 1'b0;
            so_oe_n_o <= 1'b1;
            array_go_o <= 1'b0;
            array_op_o <= FSW_OP_NONE;
            array_addr_o <= 24'h000000;
            refused_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            sr <= next_sr;
            busy_cnt <= next_busy_cnt;
            bit_idx <= next_bit_idx;
            byte_cnt <= next_byte_cnt;
            shift <= next_shift;
            cmd <= next_cmd;
            addr <= next_addr;
            wr_b1 <= next_wr_b1;
            wr_b2 <= next_wr_b2;
            reset_arm <= next_reset_arm;
            so_o <= next_so;
            so_oe_n_o <= next_so_oe_n;
            array_go_o <= next_go;
            array_op_o <= next_op;
            array_addr_o <= next_array_addr;
            refused_o <= next_refused;
        end
    end

    assign status_o = sr;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence busy_start_s;
        $rose(sr[`FSW_BIT_BUSY]);
    endsequence
    sequence busy_end_s;
        $fell(sr[`FSW_BIT_BUSY]);
    endsequence

    busy_ends_a: assert property (busy_start_s |-> ##[1:BUSY_MAX] !sr[`FSW_BIT_BUSY])
        else $error("busy did not end in time");
    latch_needed_a: assert property (busy_start_s |-> $past(sr[`FSW_BIT_LATCH]))
        else $error("operation started without write latch");
    latch_cleared_a: assert property (busy_end_s |-> !sr[`FSW_BIT_LATCH])
        else $error("write latch kept after operation");
    guard_lock_a: assert property ($changed(sr[6:2]) |-> $past(lock_ok && sr[`FSW_BIT_LATCH]))
        else $error("guard bits changed while locked");
    lockdown_hold_a: assert property ($past(sr[`FSW_BIT_LOCK_HI]) |-> $stable(sr[14:2]))
        else $error("status changed in lock-down mode");
    region_reject_a: assert property (array_go_o && array_op_o != FSW_OP_CHIP |-> $past(!region_hit))
        else $error("protected region was launched");
    chip_gate_a: assert property (array_go_o && array_op_o == FSW_OP_CHIP |-> $past(chip_ok))
        else $error("chip erase launched while guarded");
    refuse_quiet_a: assert property (refused_o |-> !sr[`FSW_BIT_BUSY] && $stable(sr))
        else $error("refusal disturbed status");
    pause_clear_a: assert property (!sr[`FSW_BIT_ERASE_PAUSE] && !sr[`FSW_BIT_PROG_PAUSE])
        else $error("pause bit set without suspend");
endmodule : fsw_status_guard

// ### hdl/fsw_consts.svh
// constants for the flash status and write-protect block
`ifndef FSW_CONSTS_SVH
`define FSW_CONSTS_SVH

// status word bit positions
`define FSW_BIT_BUSY 0
`define FSW_BIT_LATCH 1
`define FSW_BIT_GUARD_LO 2
`define FSW_BIT_GUARD_HI 6
`define FSW_BIT_LOCK_LO 7
`define FSW_BIT_LOCK_HI 8
`define FSW_BIT_QUAD 9
`define FSW_BIT_PROG_PAUSE 10
`define FSW_BIT_OTP_LO 11
`define FSW_BIT_OTP_HI 13
`define FSW_BIT_CMP 14
`define FSW_BIT_ERASE_PAUSE 15

// status word reset value and writable mask
`define FSW_SR_RESET 16'h0000
`define FSW_SR1_WR_MASK 8'hFC

// serial command codes
`define FSW_CMD_WRITE_ALLOW 8'h06
`define FSW_CMD_WRITE_FORBID 8'h04
`define FSW_CMD_READ_SR1 8'h05
`define FSW_CMD_READ_SR2 8'h35
`define FSW_CMD_STATUS_WRITE 8'h01
`define FSW_CMD_PAGE_WRITE 8'h02
`define FSW_CMD_SECT_CLEAR 8'h20
`define FSW_CMD_BLK32_CLEAR 8'h52
`define FSW_CMD_BLK64_CLEAR 8'hD8
`define FSW_CMD_CHIP_CLEAR_A 8'h60
`define FSW_CMD_CHIP_CLEAR_B 8'hC7
`define FSW_CMD_RESET_ARM 8'h66
`define FSW_CMD_RESET_GO 8'h99

// region spans (last byte offset inside an aligned region) and array size in bytes
`define FSW_SPAN_PAGE 24'h0000FF
`define FSW_SPAN_SECT 24'h000FFF
`define FSW_SPAN_BLK32 24'h007FFF
`define FSW_SPAN_BLK64 24'h00FFFF
`define FSW_ARRAY_SIZE 24'h800000

// busy duration of an internal operation
`define FSW_CLK_NS 25
`define FSW_BUSY_NS 1600
`define FSW_BUSY_CYC ((`FSW_BUSY_NS + `FSW_CLK_NS - 1) / `FSW_CLK_NS)

`endif

// ### hdl/fsw_pkg.sv
// types for the flash status and write-protect block
package fsw_pkg;
    typedef enum logic [2:0] {
        FSW_OP_NONE = 3'b000,
        FSW_OP_PROG = 3'b001,
        FSW_OP_SECT = 3'b010,
        FSW_OP_BLK32 = 3'b011,
        FSW_OP_BLK64 = 3'b100,
        FSW_OP_CHIP = 3'b101,
        FSW_OP_STATUS = 3'b110
    } fsw_op_t;

    typedef enum logic {
        FSW_IDLE = 1'b0,
        FSW_BUSY = 1'b1
    } fsw_state_t;
endpackage : fsw_pkg

// ### hdl/fsw_guard_decode.sv
// decodes guard bits and complement into a protected-range hit test
`timescale 1ns/100ps
`include "fsw_consts.svh"
module fsw_guard_decode
    import fsw_pkg::*;
(
    // protection settings
    input wire logic [4:0] guard_bits_i,
    input wire logic complement_i,
    // target region ends
    input wire logic [23:0] first_addr_i,
    input wire logic [23:0] last_addr_i,
    // result
    output logic hit_o
);
    // one address against the selected range
    function automatic logic is_guarded(input logic [23:0] addr, input logic [4:0] bits, input logic cmp);
        logic [2:0] n;
        logic [23:0] size;
        logic prot;
        n = bits[2:0];
        size = 24'h000000;
        prot = 1'b0;
        if (n == 3'h0)
            prot = 1'b0;
        else if (n == 3'h7)
            prot = 1'b1;
        else
        begin
            if (!bits[4])
                size = 24'h010000 << n; // fractions 1/64 .. 1/2
            else if (n >= 3'h4)
                size = 24'h008000; // 32 KiB part
            else
                size = 24'h000800 << n; // 4, 8, 16 KiB parts
            if (!bits[3])
                prot = (addr >= (`FSW_ARRAY_SIZE - size));
            else
                prot = (addr < size);
        end
        return prot ^ cmp; // complement inverts, incl. none/all
    endfunction : is_guarded

    // edge-anchored ranges: a region hits iff one of its ends hits
    assign hit_o = is_guarded(first_addr_i, guard_bits_i, complement_i)
        | is_guarded(last_addr_i, guard_bits_i, complement_i);
endmodule : fsw_guard_decode

// ### verification/fsw_spi_host.sv
// behavioural serial host that sends status and erase frames
`timescale 1ns/100ps
module fsw_spi_host (
    // clock
    input wire logic clk_i,
    // serial link
    input wire logic so_i,
    input wire logic so_oe_n_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic si_o
);
    logic so_seen;

    // idle link: clock low, deselected
    initial
    begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        so_seen = 1'b0;
    end

    // half of a 200 ns serial period, launched just after clk rise
    task half();
        repeat (4) @(posedge clk_i);
        #1;
    endtask : half

    // one frame of n bytes msb first, returns the last byte seen on so
    task xfer(input logic [2:0] n, input logic [39:0] d, output logic [7:0] rd);
        rd = 8'h00;
        cs_n_o = 1'b0;
        half();
        for (int i = 0; i < n * 8; i++)
        begin
            si_o = d[39 - i];
            half();
            sclk_o = 1'b1;
            // a released line shows the inverse of its last level
            so_seen = so_oe_n_i ? ~so_seen : so_i;
            rd = {rd[6:0], so_seen};
            half();
            sclk_o = 1'b0;
        end
        half();
        cs_n_o = 1'b1;
        si_o = ~si_o;
        half();
    endtask : xfer
endmodule : fsw_spi_host

// ### verification/fsw_status_guard_test.sv
// self-checking bench for the status and write-protect block
`timescale 1ns/100ps
`include "fsw_consts.svh"
module fsw_status_guard_test
    import fsw_pkg::*;
;
    typedef struct {
        logic pin;
        logic [2:0] n;
        logic [39:0] d;
        logic [2:0] op;
        logic [23:0] ea;
        logic [15:0] st;
    } fsw_row_t;

    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic write_guard_n_i = 1'b1;
    logic sclk_i, cs_n_i, si_i, so_o, so_oe_n_o, array_go_o, refused_o, got_go, got_ref;
    logic [15:0] status_o;
    fsw_op_t array_op_o;
    logic [23:0] array_addr_o, go_addr;
    logic [2:0] go_op;
    logic [7:0] rd;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int busy_cnt = 0;

    // op 0 no answer, 7 refused, else accepted with that op
    fsw_row_t rows [44] = '{
        '{1'h1,3'h4,40'h2000000000,3'h7,24'h0,16'h0000}, '{1'h1,3'h1,40'h0600000000,3'h0,24'h0,16'h0002},
        '{1'h1,3'h1,40'h0400000000,3'h0,24'h0,16'h0000}, '{1'h1,3'h1,40'h0600000000,3'h0,24'h0,16'h0002},
        '{1'h0,3'h2,40'h0104000000,3'h6,24'h0,16'h0004}, '{1'h1,3'h1,40'h0600000000,3'h0,24'h0,16'h0006},
        '{1'h1,3'h4,40'h207F000000,3'h7,24'h0,16'h0006}, '{1'h1,3'h4,40'h2000000000,3'h2,24'h0,16'h0004},
        '{1'h1,3'h1,40'h0600000000,3'h0,24'h0,16'h0006}, '{1'h1,3'h1,40'h6000000000,3'h7,24'h0,16'h0006},
        '{1'h1,3'h4,40'h5201234500,3'h3,24'h010000,16'h0004}, '{1'h1,3'h1,40'h0600000000,3'h0,24'h0,16'h0006},
        '{1'h1,3'h4,40'hD87E000000,3'h7,24'h0,16'h0006}, '{1'h1,3'h4,40'hD87D000000,3'h4,24'h7D0000,16'h0004},
        '{1'h1,3'h1,40'h0600000000,3'h0,24'h0,16'h0006}, '{1'h1,3'h5,40'h02000100AA,3'h1,24'h000100,16'h0004},
        '{1'h1,3'h1,40'h0600000000,3'h0,24'h0,16'h0006}, '{1'h1,3'h3,40'h0100400000,3'h6,24'h0,16'h4000},
        '{1'h1,3'h1,40'h0600000000,3'h0,24'h0,16'h4002}, '{1'h1,3'h4,40'h2000000000,3'h7,24'h0,16'h4002},
        '{1'h1,3'h1,40'hC700000000,3'h7,24'h0,16'h4002}, '{1'h1,3'h3,40'h011C400000,3'h6,24'h0,16'h401C},
        '{1'h1,3'h1,40'h0600000000,3'h0,24'h0,16'h401E}, '{1'h1,3'h1,40'hC700000000,3'h5,24'h0,16'h401C},
        '{1'h1,3'h1,40'h0600000000,3'h0,24'h0,16'h401E}, '{1'h1,3'h3,40'h0164000000,3'h6,24'h0,16'h0064},
        '{1'h1,3'h1,40'h0600000000,3'h0,24'h0,16'h0066}, '{1'h1,3'h4,40'h2000000000,3'h7,24'h0,16'h0066},
        '{1'h1,3'h4,40'h2000100000,3'h2,24'h001000,16'h0064},
        '{1'h1,3'h1,40'h0600000000,3'h0,24'h0,16'h0066}, '{1'h1,3'h3,40'h0180000000,3'h6,24'h0,16'h0080},
        '{1'h0,3'h1,40'h0600000000,3'h0,24'h0,16'h0082}, '{1'h0,3'h3,40'h0100000000,3'h7,24'h0,16'h0082},
        '{1'h1,3'h3,40'h0100000000,3'h6,24'h0,16'h0000}, '{1'h1,3'h1,40'h0600000000,3'h0,24'h0,16'h0002},
        '{1'h1,3'h3,40'h0100010000,3'h6,24'h0,16'h0100}, '{1'h1,3'h1,40'h0600000000,3'h0,24'h0,16'h0102},
        '{1'h1,3'h3,40'h0100000000,3'h7,24'h0,16'h0102}, '{1'h1,3'h1,40'h0600000000,3'h0,24'h0,16'h0002},
        '{1'h1,3'h3,40'h0180010000,3'h6,24'h0,16'h0180}, '{1'h1,3'h1,40'h0600000000,3'h0,24'h0,16'h0182},
        '{1'h1,3'h2,40'h0104000000,3'h7,24'h0,16'h0182}, '{1'h1,3'h1,40'h6600000000,3'h0,24'h0,16'h0182},
        '{1'h1,3'h1,40'h9900000000,3'h0,24'h0,16'h0180}
    };

    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;

    fsw_spi_host host (.clk_i(clk_i), .so_i(so_o), .so_oe_n_i(so_oe_n_o),
        .sclk_o(sclk_i), .cs_n_o(cs_n_i), .si_o(si_i));

    fsw_status_guard uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
        .si_i(si_i), .write_guard_n_i(write_guard_n_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
        .status_o(status_o), .array_go_o(array_go_o), .array_op_o(array_op_o),
        .array_addr_o(array_addr_o), .refused_o(refused_o));

    // pulse capture, busy length and run ceiling
    always @(posedge clk_i)
    begin
        cycles <= cycles + 1;
        // running op is held while busy, status writes included
        if (status_o[`FSW_BIT_BUSY] === 1'b1)
        begin
            busy_cnt <= busy_cnt + 1;
            go_op <= array_op_o;
        end
        if (refused_o === 1'b1) got_ref <= 1'b1;
        if (array_go_o === 1'b1)
        begin
            got_go <= 1'b1;
            go_addr <= array_addr_o;
        end
        if (cycles == 40000)
        begin
            n_errors++;
            end_sim();
        end
    end

    task chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task end_sim();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    // reset stands in for a power cycle
    task do_reset();
        reset_n_i = 1'b0;
        repeat (6) @(posedge clk_i);
        #1;
        chk("reset", {status_o, so_oe_n_o, array_go_o, refused_o, array_op_o}, 22'h000020);
        reset_n_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
    endtask : do_reset

    // main sequence
    initial
    begin
        do_reset();
        foreach (rows[i])
        begin
            if (i == 38) do_reset();
            write_guard_n_i = rows[i].pin;
            got_go = 1'b0;
            got_ref = 1'b0;
            busy_cnt = 0;
            host.xfer(rows[i].n, rows[i].d, rd);
            repeat (8) @(posedge clk_i);
            for (int k = 0; k < 100 && status_o[`FSW_BIT_BUSY] !== 1'b0; k++) @(posedge clk_i);
            #1;
            chk("refused", got_ref, rows[i].op == 3'h7);
            chk("accepted", got_go, rows[i].op != 3'h0 && rows[i].op < 3'h6);
            // status writes run busy without an array pulse
            if (rows[i].op != 3'h0 && rows[i].op != 3'h7)
            begin
                chk("op", go_op, rows[i].op);
                chk("busy length", busy_cnt, `FSW_BUSY_CYC);
                if (rows[i].op != 3'h6) chk("addr", go_addr, rows[i].ea);
            end
            else
                chk("busy idle", busy_cnt, 0);
            chk("status", status_o, rows[i].st);
        end
        host.xfer(3'h2, 40'h0500000000, rd);
        chk("read low", rd, 8'h80);
        host.xfer(3'h2, 40'h3500000000, rd);
        chk("read high", rd, 8'h01);
        chk("so released", so_oe_n_o, 1'b1);
        end_sim();
    end
endmodule : fsw_status_guard_test
